// file: logic/fcmd_map.svh
// Constants for the serial flash command host: opcodes, phase sizes and timing.
// Assumes a 25 MHz system clock; included by bare name.
// How it works
// - B5h: address, eight dummy, one byte read
// - 85h: address, eight dummy, one byte read
// - 01h sends exactly one status byte
// - B1h: address then one byte, single line
// - 81h: address then one byte, single line
// - C5h sends one extended address byte
// - 02h: address, 1 to 256 bytes, single line
// - 32h: single address, data on four lines
// - C2h: address and data on four lines
// - 12h always sends four address bytes
// - 34h: four address bytes, quad data
// - 3Eh: four quad address bytes, quad data
// - 20h: address only, no data phase
`ifndef FCMD_MAP_SVH
`define FCMD_MAP_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FCMD_OP_RD_FLAG   8'h70
`define FCMD_OP_RD_NVCFG  8'hb5
`define FCMD_OP_RD_VCFG   8'h85
`define FCMD_OP_RD_XADDR  8'hc8
`define FCMD_OP_WR_STAT   8'h01
`define FCMD_OP_WR_NVCFG  8'hb1
`define FCMD_OP_WR_VCFG   8'h81
`define FCMD_OP_WR_XADDR  8'hc5
`define FCMD_OP_PROG      8'h02
`define FCMD_OP_PROG_Q    8'h32
`define FCMD_OP_PROG_XQ   8'hc2
`define FCMD_OP_PROG4     8'h12
`define FCMD_OP_PROG4_Q   8'h34
`define FCMD_OP_PROG4_XQ  8'h3e
`define FCMD_OP_ERASE_SEC 8'h20
// ----------------------------------------
// Phase sizes and timing
// ----------------------------------------
`define FCMD_DUMMY_CYC    6'h08
`define FCMD_BYTE_BITS    6'h08
`define FCMD_QUAD_BITS    6'h02
`define FCMD_PAGE_BYTES   256
`define FCMD_CLK_NS       40
`define FCMD_SCK_DIV      4
`define FCMD_CSH_NS       50
`define FCMD_CSH_CYC      ((`FCMD_CSH_NS + `FCMD_CLK_NS - 1) / `FCMD_CLK_NS)
`endif

// file: logic/fcmd_pkg.sv
// Types for the serial flash command host.
// Assumes the constants header is compiled alongside.
`default_nettype none
package fcmd_pkg;
    // Frame sequencer states
    typedef enum logic [2:0] {
        FCMD_IDLE, FCMD_OPC, FCMD_ADDR, FCMD_DUMMY,
        FCMD_LOAD, FCMD_DATA, FCMD_GAP
    } fcmd_state_type;
    // Direction of the data phase
    typedef enum logic [1:0] {FCMD_DNONE, FCMD_DWRITE, FCMD_DREAD} fcmd_dir_type;
    // Per-opcode phase layout
    typedef struct packed {
        logic [2:0]   abytes;  // Address bytes, zero when absent
        logic         aquad;   // Address on four lines
        logic         dummy;   // Eight dummy clocks present
        fcmd_dir_type dir;     // Data phase direction
        logic         dquad;   // Data on four lines
        logic         one;     // Exactly one data byte
    } fcmd_dec_type;
endpackage
`default_nettype wire

// file: logic/fcmd_host.sv
// Host side of a serial NOR flash: frames commands on SCK, CS and IO0..IO3.
// Assumes pins are asynchronous to i_clk and the flash reads on rising SCK.
`timescale 1ns/1ps
`include "fcmd_map.svh"
`default_nettype none

// ----------------------------------------
// Write data FIFO
// ----------------------------------------
module fcmd_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_valid,
    input  wire logic [W-1:0] i_data,
    output var  logic         o_ready,
    output var  logic         o_valid,
    output logic      [W-1:0] o_data,
    input  wire logic         i_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];     // Storage, no reset needed
    logic [AW-1:0] wp;         // Write pointer
    logic [AW-1:0] rp;         // Read pointer
    logic [AW:0]   cnt;        // Fill level
    logic [AW:0]   next_cnt;   // Fill level after this edge
    logic          push;
    logic          pop;

    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    assign o_data = mem[rp];
    assign next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // Storage write; D must be a power of two so pointers wrap
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wp] <= i_data;
        end
    end

    // Pointers and level
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end
        else
        begin
            wp <= wp + AW'(push);
            rp <= rp + AW'(pop);
            cnt <= next_cnt;
        end
    end

    // Flags registered from the next level so they are honest at once
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_ready <= 1'b0;
            o_valid <= 1'b0;
        end
        else
        begin
            o_ready <= next_cnt != (AW+1)'(D);
            o_valid <= next_cnt != '0;
        end
    end
endmodule

// ----------------------------------------
// Command host
// ----------------------------------------
module fcmd_host #(
    parameter int FIFO_DEPTH = 32,
    parameter int CSH_CYC    = `FCMD_CSH_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_cmd_valid,  // Command request
    input  wire logic [7:0]  i_cmd_op,     // Opcode
    input  wire logic [31:0] i_cmd_addr,   // Flash address
    input  wire logic [7:0]  i_cmd_len,    // Data bytes minus one
    input  wire logic        i_four_byte,  // Four-byte address mode
    output var  logic        o_cmd_ready,  // Ready for a command
    input  wire logic        i_wr_valid,   // Write byte offered
    input  wire logic [7:0]  i_wr_data,    // Write byte
    output var  logic        o_wr_ready,   // FIFO has room
    output var  logic        o_rd_valid,   // Read byte pulse
    output var  logic [7:0]  o_rd_data,    // Read byte
    output var  logic        o_sck,        // Serial clock
    output var  logic        o_cs_b,       // Chip select
    output var  logic [3:0]  o_io,         // IO lines out
    output var  logic [3:0]  o_io_oe_b,    // Low while driving
    input  wire logic [3:0]  i_io          // IO lines in
);
    fcmd_pkg::fcmd_state_type st;        // Sequencer state
    fcmd_pkg::fcmd_state_type next_st;   // Next sequencer state
    fcmd_pkg::fcmd_state_type after;     // State after a finished phase
    fcmd_pkg::fcmd_state_type data_st;   // Entry of the data phase
    fcmd_pkg::fcmd_dec_type   dec;       // Layout of the running command
    logic [7:0]  op;                     // Running opcode
    logic [1:0]  ph;                     // Position within one SCK period
    logic [5:0]  bcnt;                   // Bit times left in phase or byte
    logic [31:0] sh;                     // Outgoing shift register
    logic [7:0]  left;                   // Data bytes left after this one
    logic [7:0]  rd_sh;                  // Incoming byte
    logic [3:0]  io_m;                   // Sync stage one
    logic [3:0]  io_s;                   // Sync stage two
    logic [7:0]  gap;                    // CS high countdown
    logic        take;
    logic        bit_end;
    logic        reload;
    logic        quad_now;
    logic        f_valid;
    logic [7:0]  f_data;
    logic [31:0] cmd_addr;               // Address of running command
    logic        frame_on;               // Frame active
    fcmd_pkg::fcmd_dec_type dec_in;      // Layout of the offered command

    // Opcode to phase layout
    function automatic fcmd_pkg::fcmd_dec_type decode(input logic [7:0] c, input logic four);
        fcmd_pkg::fcmd_dec_type d;
        logic [2:0] ab;
        d = '0;
        ab = four ? 3'h4 : 3'h3;
        case (c)
            `FCMD_OP_RD_FLAG, `FCMD_OP_RD_XADDR:
                d.dir = fcmd_pkg::FCMD_DREAD;
            `FCMD_OP_RD_NVCFG, `FCMD_OP_RD_VCFG:
            begin
                d.abytes = ab;
                d.dummy = 1'b1;
                d.dir = fcmd_pkg::FCMD_DREAD;
                d.one = 1'b1;
            end
            `FCMD_OP_WR_STAT, `FCMD_OP_WR_XADDR:
            begin
                d.dir = fcmd_pkg::FCMD_DWRITE;
                d.one = 1'b1;
            end
            `FCMD_OP_WR_NVCFG, `FCMD_OP_WR_VCFG:
            begin
                d.abytes = ab;
                d.dir = fcmd_pkg::FCMD_DWRITE;
                d.one = 1'b1;
            end
            `FCMD_OP_PROG, `FCMD_OP_PROG_Q, `FCMD_OP_PROG_XQ:
            begin
                d.abytes = ab;
                d.dir = fcmd_pkg::FCMD_DWRITE;
                d.dquad = c != `FCMD_OP_PROG;
                d.aquad = c == `FCMD_OP_PROG_XQ;
            end
            `FCMD_OP_PROG4, `FCMD_OP_PROG4_Q, `FCMD_OP_PROG4_XQ:
            begin
                d.abytes = 3'h4;
                d.dir = fcmd_pkg::FCMD_DWRITE;
                d.dquad = c != `FCMD_OP_PROG4;
                d.aquad = c == `FCMD_OP_PROG4_XQ;
            end
            `FCMD_OP_ERASE_SEC:
                d.abytes = ab;
            // Anything else is sent as a bare opcode
            default:
                d = '0;
        endcase
        return d;
    endfunction

    assign take = o_cmd_ready && i_cmd_valid;
    assign dec_in = decode(i_cmd_op, i_four_byte);
    assign bit_end = ph == 2'(`FCMD_SCK_DIV - 1);
    assign reload = bit_end && bcnt == 6'h01;
    assign quad_now = (st == fcmd_pkg::FCMD_ADDR && dec.aquad)
                   || (st == fcmd_pkg::FCMD_DATA && dec.dquad);

    // ----------------------------------------
    // Write data path
    // ----------------------------------------
    // Buffers up to FIFO_DEPTH write bytes so the caller may run ahead of SCK
    fcmd_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_valid (i_wr_valid),
        .i_data  (i_wr_data),
        .o_ready (o_wr_ready),
        .o_valid (f_valid),
        .o_data  (f_data),
        .i_ready (st == fcmd_pkg::FCMD_LOAD)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Phase order within one frame
    always_comb
    begin
        if (dec.dir == fcmd_pkg::FCMD_DWRITE)
            data_st = fcmd_pkg::FCMD_LOAD;
        else if (dec.dir == fcmd_pkg::FCMD_DREAD)
            data_st = fcmd_pkg::FCMD_DATA;
        else
            data_st = fcmd_pkg::FCMD_GAP;
        if (st == fcmd_pkg::FCMD_OPC && dec.abytes != 3'h0)
            after = fcmd_pkg::FCMD_ADDR;
        else if (st != fcmd_pkg::FCMD_DUMMY && dec.dummy)
            after = fcmd_pkg::FCMD_DUMMY;
        else
            after = data_st;
    end

    // Next state
    always_comb
    begin
        next_st = st;
        unique case (st)
            fcmd_pkg::FCMD_IDLE:
                if (take)
                    next_st = fcmd_pkg::FCMD_OPC;
            fcmd_pkg::FCMD_OPC, fcmd_pkg::FCMD_ADDR, fcmd_pkg::FCMD_DUMMY:
                if (reload)
                    next_st = after;
            fcmd_pkg::FCMD_LOAD:
                // Stall with SCK low until the FIFO offers a byte
                if (f_valid)
                    next_st = fcmd_pkg::FCMD_DATA;
            fcmd_pkg::FCMD_DATA:
                if (reload && left == 8'h00)
                    next_st = fcmd_pkg::FCMD_GAP;
                else if (reload && dec.dir == fcmd_pkg::FCMD_DWRITE)
                    next_st = fcmd_pkg::FCMD_LOAD;
            fcmd_pkg::FCMD_GAP:
                if (gap == 8'h00)
                    next_st = fcmd_pkg::FCMD_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            st <= fcmd_pkg::FCMD_IDLE;
        else
            st <= next_st;
    end

    // Command latch
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            dec <= '0;
            op <= 8'h00;
        end
        else if (take)
        begin
            dec <= dec_in;
            op <= i_cmd_op;
        end
    end

    // Command acceptance: one command per frame
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_cmd_ready <= 1'b0;
        else
            o_cmd_ready <= next_st == fcmd_pkg::FCMD_IDLE && !take;
    end

    // SCK phase counter, held at zero outside shifting states
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            ph <= 2'h0;
        else if (st == fcmd_pkg::FCMD_IDLE || st == fcmd_pkg::FCMD_LOAD
                 || st == fcmd_pkg::FCMD_GAP)
            ph <= 2'h0;
        else
            ph <= ph + 2'h1;
    end

    // Shift register and bit counter, loaded on each phase entry
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sh <= 32'h0;
            bcnt <= 6'h00;
        end
        else if (take)
        begin
            sh <= {i_cmd_op, 24'h0};
            bcnt <= `FCMD_BYTE_BITS;
        end
        else if (st == fcmd_pkg::FCMD_OPC && next_st == fcmd_pkg::FCMD_ADDR)
        begin
            // Three-byte addresses are left justified
            sh <= dec.abytes == 3'h4 ? cmd_addr : {cmd_addr[23:0], 8'h00};
            bcnt <= dec.aquad ? {2'b0, dec.abytes, 1'b0} : {dec.abytes, 3'b0};
        end
        else if (next_st == fcmd_pkg::FCMD_DUMMY && st != fcmd_pkg::FCMD_DUMMY)
            bcnt <= `FCMD_DUMMY_CYC;
        else if (st == fcmd_pkg::FCMD_LOAD && f_valid)
        begin
            sh <= {f_data, 24'h0};
            bcnt <= dec.dquad ? `FCMD_QUAD_BITS : `FCMD_BYTE_BITS;
        end
        else if (next_st == fcmd_pkg::FCMD_DATA && (st != next_st || reload))
            bcnt <= `FCMD_BYTE_BITS;
        else if (bit_end)
        begin
            sh <= quad_now ? {sh[27:0], 4'h0} : {sh[30:0], 1'b0};
            bcnt <= bcnt - 6'h01;
        end
    end

    // Address latch
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cmd_addr <= 32'h0;
        else if (take)
            cmd_addr <= i_cmd_addr;
    end

    // Data bytes remaining; single-byte commands ignore the length
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            left <= 8'h00;
        else if (take)
            left <= dec_in.one ? 8'h00 : i_cmd_len;
        else if (st == fcmd_pkg::FCMD_DATA && reload && left != 8'h00)
            left <= left - 8'h01;
    end

    // CS high time between frames
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            gap <= 8'h00;
        else if (st != fcmd_pkg::FCMD_GAP)
            gap <= 8'(CSH_CYC - 1);
        else if (gap != 8'h00)
            gap <= gap - 8'h01;
    end

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    // All pin outputs share one register stage so they stay aligned
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_sck <= 1'b0;
            o_cs_b <= 1'b1;
            o_io <= 4'h0;
            o_io_oe_b <= 4'hf;
        end
        else
        begin
            o_cs_b <= st == fcmd_pkg::FCMD_IDLE || st == fcmd_pkg::FCMD_GAP;
            o_sck <= st != fcmd_pkg::FCMD_LOAD && frame_on && ph[1];
            o_io <= quad_now ? sh[31:28] : {3'h0, sh[31]};
            if (st == fcmd_pkg::FCMD_OPC || (st == fcmd_pkg::FCMD_ADDR && !dec.aquad)
                || (st == fcmd_pkg::FCMD_DATA && dec.dir == fcmd_pkg::FCMD_DWRITE && !dec.dquad))
                o_io_oe_b <= 4'he;
            else if (quad_now && (st == fcmd_pkg::FCMD_ADDR || dec.dir == fcmd_pkg::FCMD_DWRITE))
                o_io_oe_b <= 4'h0;
            else
                o_io_oe_b <= 4'hf;
        end
    end
    assign frame_on = st != fcmd_pkg::FCMD_IDLE && st != fcmd_pkg::FCMD_GAP;

    // Pin input synchroniser
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            io_m <= 4'h0;
            io_s <= 4'h0;
        end
        else
        begin
            io_m <= i_io;
            io_s <= io_m;
        end
    end

    // Read capture on IO1 at the end of each bit time; the sync delay
    // lands the sample mid-way through the low half of SCK
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rd_sh <= 8'h00;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
        end
        else
        begin
            o_rd_valid <= 1'b0;
            if (st == fcmd_pkg::FCMD_DATA && dec.dir == fcmd_pkg::FCMD_DREAD && bit_end)
            begin
                rd_sh <= {rd_sh[6:0], io_s[1]};
                if (bcnt == 6'h01)
                begin
                    o_rd_valid <= 1'b1;
                    o_rd_data <= {rd_sh[6:0], io_s[1]};
                end
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    AST_OPC_ONE_LANE: assert property (st == fcmd_pkg::FCMD_OPC |=> o_io_oe_b == 4'he)
        else $error("opcode not on one line");
    AST_DUMMY_EIGHT: assert property ($rose(st == fcmd_pkg::FCMD_DUMMY)
        |-> (st == fcmd_pkg::FCMD_DUMMY) ##31 (st == fcmd_pkg::FCMD_DUMMY) ##1 (st == fcmd_pkg::FCMD_DATA))
        else $error("dummy phase not eight clocks");
    AST_CFG_ONE_BYTE: assert property (st == fcmd_pkg::FCMD_DUMMY |-> left == 8'h00)
        else $error("config read longer than one byte");
    AST_STAT_ONE: assert property (take && i_cmd_op == `FCMD_OP_WR_STAT |=> left == 8'h00 && dec.abytes == 3'h0)
        else $error("status write layout wrong");
    AST_LAST_BYTE: assert property (st == fcmd_pkg::FCMD_DATA && reload && left == 8'h00
        |=> st == fcmd_pkg::FCMD_GAP ##1 o_cs_b)
        else $error("frame not closed after last byte");
    AST_QUAD_DATA: assert property (st == fcmd_pkg::FCMD_DATA && dec.dquad |=> o_io_oe_b == 4'h0)
        else $error("quad data not on four lines");
    AST_QUAD_ADDR: assert property (st == fcmd_pkg::FCMD_ADDR && op == `FCMD_OP_PROG_XQ |=> o_io_oe_b == 4'h0)
        else $error("quad address not on four lines");
    AST_FOUR_ADDR: assert property (st == fcmd_pkg::FCMD_OPC && next_st == fcmd_pkg::FCMD_ADDR
        && op == `FCMD_OP_PROG4 |=> bcnt == 6'h20)
        else $error("four byte program lacks four address bytes");
    AST_ERASE_NODATA: assert property (st == fcmd_pkg::FCMD_ADDR && op == `FCMD_OP_ERASE_SEC && reload
        |=> st == fcmd_pkg::FCMD_GAP)
        else $error("erase has a data phase");
    AST_FRAME_GAP: assert property ($rose(o_cs_b) |-> o_cs_b[*2])
        else $error("chip select high time too short");
endmodule
`default_nettype wire

// file: tb/fcmd_flash_model.sv
// Behavioural serial flash facing the command host.
// Assumes mode 0 framing: sample on rising SCK, drive on falling SCK.
`timescale 1ns/1ps
`default_nettype none
module fcmd_flash_model #(
    parameter logic [7:0] FLAG = 8'h80  // Fixed flag status byte
) (
    input  wire logic       i_sck,
    input  wire logic       i_cs_b,
    input  wire logic [3:0] i_io,
    input  wire logic       i_four,
    output var  logic       o_rd_en,
    output var  logic       o_rd_bit
);
    int          n, nf, ae, ds;       // Edges, frames, address edges, data start
    logic [2:0]  ab;                  // Address bytes
    logic        aq, dm, rd, dq;      // Quad address, dummy, read, quad data
    logic [7:0]  op, sh, rv;          // Opcode, shifter, read value
    logic [7:0]  st, nv, v, x;        // Writable registers
    logic [31:0] adr;                 // Captured address
    logic [7:0]  got[$];              // Bytes written in this frame
    initial
    begin
        {st, nv, v, x} = 32'h0;
        {o_rd_en, o_rd_bit} = 2'h0;
    end
    // ----------------------------------------
    // Phase layout per opcode
    // ----------------------------------------
    always_comb
    begin
        {ab, aq, dm, rd, dq} = {i_four ? 3'h4 : 3'h3, 4'h0};
        case (op)
            8'h70, 8'hc8: {ab, rd} = 4'h1;
            8'hb5, 8'h85: {dm, rd} = 2'h3;
            8'h01, 8'hc5: ab = 3'h0;
            8'h32: dq = 1'b1;
            8'hc2: {aq, dq} = 2'h3;
            8'h12: ab = 3'h4;
            8'h34: {ab, dq} = 4'h9;
            8'h3e: {ab, aq, dq} = 5'h13;
            default: ;
        endcase
        ae = aq ? ab * 2 : ab * 8;
        ds = 8 + ae + (dm ? 8 : 0);
        rv = op == 8'h70 ? FLAG : op == 8'hb5 ? nv : op == 8'h85 ? v : x;
    end
    // Frame start: one command per chip-select assertion
    always @(negedge i_cs_b)
    begin
        n = 0;
        adr = 0;
        got.delete();
        nf++;
    end
    // Capture on rising SCK inside a frame
    always @(posedge i_sck)
    begin
        if (!i_cs_b)
        begin
            if (n < 8)
                op = {op[6:0], i_io[0]};
            else if (n < 8 + ae)
                adr = aq ? {adr[27:0], i_io} : {adr[30:0], i_io[0]};
            else if (n >= ds && !rd)
            begin
                sh = dq ? {sh[3:0], i_io} : {sh[6:0], i_io[0]};
                if ((n - ds + 1) % (dq ? 2 : 8) == 0)
                    got.push_back(sh);
            end
            n++;
        end
    end
    // Read bits move on falling SCK; streams repeat the same byte
    always @(negedge i_sck)
    begin
        o_rd_en = !i_cs_b && rd && n >= ds;
        if (o_rd_en)
            o_rd_bit = rv[7 - (n - ds) % 8];
    end
    // Frame end commits single-byte register writes
    always @(posedge i_cs_b)
    begin
        o_rd_en = 0;
        if (got.size() == 1)
            case (op)
                8'h01: st = got[0];
                8'hb1: nv = got[0];
                8'h81: v = got[0];
                8'hc5: x = got[0];
                default: ;
            endcase
    end
endmodule
`default_nettype wire

// file: tb/flash_register_program_cmd_decode_bench.sv
// Self-checking bench for the flash command host.
// Assumes the behavioural flash model answers on the pins.
`timescale 1ns/1ps
`default_nettype none
module flash_register_program_cmd_decode_bench;
    localparam logic [7:0] FLAG = 8'h80;
    logic        i_clk = 0, i_rst_b = 0, i_cmd_valid = 0, i_four_byte = 0, i_wr_valid = 0, tog = 0;
    logic [7:0]  i_cmd_op = 0, i_cmd_len = 0, i_wr_data = 0, o_rd_data;
    logic [31:0] i_cmd_addr = 0;
    logic        o_cmd_ready, o_wr_ready, o_rd_valid, o_sck, o_cs_b, rd_en, rd_bit, full_seen = 0;
    logic [3:0]  o_io, o_io_oe_b, io_in;
    int          seed = 94, n_errors = 0, num_checks = 0;
    logic [7:0]  rdq[$], wq[$], mir[3] = '{3{8'h00}};
    logic [7:0]  ops[15] = '{8'h70, 8'hb5, 8'h85, 8'hc8, 8'h01, 8'hb1, 8'h81, 8'hc5,
                             8'h02, 8'h32, 8'hc2, 8'h12, 8'h34, 8'h3e, 8'h20};
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) tog <= ~tog;
    // Released lines show a changing pattern, never a stale value
    always_comb
        for (int k = 0; k < 4; k++)
            io_in[k] = !o_io_oe_b[k] ? o_io[k] : (k == 1 && rd_en) ? rd_bit : tog;
    // Read pulses and FIFO refusals seen mid-cycle
    always @(negedge i_clk)
    begin
        if (o_rd_valid === 1'b1)
            rdq.push_back(o_rd_data);
        if (i_wr_valid === 1'b1 && o_wr_ready === 1'b0)
            full_seen = 1;
    end
    fcmd_host u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
        .i_cmd_addr(i_cmd_addr), .i_cmd_len(i_cmd_len), .i_four_byte(i_four_byte), .o_cmd_ready(o_cmd_ready),
        .i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .o_sck(o_sck), .o_cs_b(o_cs_b), .o_io(o_io), .o_io_oe_b(o_io_oe_b), .i_io(io_in));
    fcmd_flash_model #(.FLAG(FLAG)) u_flash (.i_sck(o_sck), .i_cs_b(o_cs_b), .i_io(io_in),
        .i_four(i_four_byte), .o_rd_en(rd_en), .o_rd_bit(rd_bit));
    // ----------------------------------------
    // Expectations
    // ----------------------------------------
    function automatic int abytes(input logic [7:0] op, input logic f);
        if (op inside {8'h12, 8'h34, 8'h3e})
            return 4;
        if (op inside {8'h70, 8'hc8, 8'h01, 8'hc5})
            return 0;
        return f ? 4 : 3;
    endfunction
    function automatic int nbytes(input logic [7:0] op, input logic [7:0] len);
        if (op == 8'h20)
            return 0;
        return (op inside {8'h70, 8'hc8, 8'h02, 8'h32, 8'hc2, 8'h12, 8'h34, 8'h3e}) ? len + 1 : 1;
    endfunction
    // Rising SCK edges in the frame: opcode, address, dummy, data
    function automatic int edges(input logic [7:0] op, input logic f, input logic [7:0] len);
        int e;
        e = 8 + abytes(op, f) * ((op inside {8'hc2, 8'h3e}) ? 2 : 8) + ((op inside {8'hb5, 8'h85}) ? 8 : 0);
        return e + nbytes(op, len) * ((op inside {8'h32, 8'hc2, 8'h34, 8'h3e}) ? 2 : 8);
    endfunction
    // ----------------------------------------
    // Drivers and checks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait; running out ends the run
    task automatic wt(ref logic s, input logic v);
        int k;
        for (k = 0; k < 20000 && s !== v; k++)
            @(negedge i_clk);
        if (k == 20000)
        begin
            chk("wait", v, s);
            summarize();
        end
    endtask
    task automatic push(input int gap);
        foreach (wq[k])
        begin
            if (k == 3 || ($random(seed) & 7) == 0)
            begin
                i_wr_valid = 0;
                repeat (gap) @(posedge i_clk);
                #1;
            end
            i_wr_data = wq[k];
            i_wr_valid = 1;
            wt(o_wr_ready, 1'b1);
            @(posedge i_clk);
            #1;
        end
        i_wr_valid = 0;
    endtask
    task automatic run(input logic [7:0] op, input logic f, input logic [7:0] len, input int dly, input int gap);
        int nw, nr, a, nf0;
        logic [31:0] ad;
        ad = $random(seed);
        a = abytes(op, f);
        nr = (op inside {8'h70, 8'hb5, 8'h85, 8'hc8}) ? nbytes(op, len) : 0;
        nw = nr ? 0 : nbytes(op, len);
        wq.delete();
        rdq.delete();
        nf0 = u_flash.nf;
        for (int k = 0; k < nw; k++)
            wq.push_back(8'($random(seed)));
        fork
            push(gap);
            begin
                repeat (dly) @(posedge i_clk);
                #1;
                {i_cmd_op, i_cmd_addr, i_cmd_len, i_four_byte, i_cmd_valid} = {op, ad, len, f, 1'b1};
                wt(o_cmd_ready, 1'b1);
                @(posedge i_clk);
                #1;
                i_cmd_valid = 0;
                wt(o_cs_b, 1'b0);
                wt(o_cmd_ready, 1'b1);
            end
        join
        chk("frames", nf0 + 1, u_flash.nf);
        chk("opcode", op, u_flash.op);
        chk("edges", edges(op, f, len), u_flash.n);
        chk("address", a == 4 ? ad : a == 3 ? {8'h00, ad[23:0]} : 0, u_flash.adr);
        chk("write count", nw, u_flash.got.size());
        foreach (wq[k])
            chk("write byte", wq[k], u_flash.got[k]);
        chk("read count", nr, rdq.size());
        foreach (rdq[k])
            chk("read byte", op == 8'h70 ? FLAG : op == 8'hb5 ? mir[0] : op == 8'h85 ? mir[1] : mir[2], rdq[k]);
        if (nw == 1 && op inside {8'hb1, 8'h81, 8'hc5})
            mir[op == 8'hb1 ? 0 : op == 8'h81 ? 1 : 2] = wq[0];
        @(posedge i_clk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge i_clk);
        #1;
        i_rst_b = 1;
        @(posedge i_clk);
        #1;
        // Second pass reads back what the first pass wrote
        for (int f = 0; f < 2; f++)
            foreach (ops[i])
                run(ops[i], f[0], 8'($random(seed) & 15), 1, 4);
        run(8'h02, 1'b0, 8'hff, 60, 4);
        chk("fifo refused", 1, full_seen);
        run(8'h3e, 1'b1, 8'h00, 1, 100);
        run(8'hc8, 1'b0, 8'hff, 1, 4);
        summarize();
    end
endmodule
`default_nettype wire
